// *** tdmr_pkg.sv ***
`default_nettype none
package tdmr_pkg;
    // byte indices within the diagnostic page; byte address on the bus is four times the index
    localparam logic [7:0] IDX_THRESH_FIRST = 8'h00;
    localparam logic [7:0] IDX_THRESH_LAST = 8'h27;
    localparam logic [7:0] IDX_CAL_FIRST = 8'h37;
    localparam logic [7:0] IDX_CAL_LAST = 8'h5e;
    localparam logic [7:0] IDX_CHECKSUM = 8'h5f;
    localparam logic [7:0] IDX_RT_FIRST = 8'h60;
    localparam logic [7:0] IDX_RT_LAST = 8'h69;
    localparam logic [7:0] IDX_STATUS = 8'h6e;
    localparam logic [7:0] IDX_ALARM_PRI = 8'h70;
    localparam logic [7:0] IDX_ALARM_RX = 8'h71;
    localparam logic [7:0] IDX_WARN_PRI = 8'h74;
    localparam logic [7:0] IDX_WARN_RX = 8'h75;
    localparam logic [7:0] IDX_LEGACY = 8'h7f;
    localparam logic [7:0] IDX_USER_FIRST = 8'h80;
    localparam logic [7:0] IDX_USER_LAST = 8'hf7;
    localparam int USER_BYTES = 120;
    localparam int THRESH_BYTES = 40;
    localparam int CAL_BYTES = 40;
    localparam int PAGE_ADDR_BITS = 10;
    // status/control bit positions
    localparam int ST_TXDIS_PIN = 7;
    localparam int ST_SOFT_TXOFF = 6;
    localparam int ST_RATE_SEL = 4;
    localparam int ST_TX_FAULT = 2;
    localparam int ST_SIG_ABSENT = 1;
    localparam int ST_DATA_NOT_READY = 0;
    // receive flag byte bit positions
    localparam int RX_HI_BIT = 7;
    localparam int RX_LO_BIT = 6;
    // measurement channels, in flag order from the top bit down
    localparam int NUM_CH = 5;
    localparam int CH_TEMP = 0;
    localparam int CH_VCC = 1;
    localparam int CH_BIAS = 2;
    localparam int CH_TXPWR = 3;
    localparam int CH_RXPWR = 4;
    localparam int READING_W = 16;
    // threshold layout: eight bytes per channel, msb first
    localparam int TH_BYTES_PER_CH = 8;
    localparam int TH_HI_ALARM = 0;
    localparam int TH_LO_ALARM = 2;
    localparam int TH_HI_WARN = 4;
    localparam int TH_LO_WARN = 6;
    // reading scales
    localparam int TEMP_STEPS_PER_DEGC = 256;
    localparam int VCC_UV_PER_COUNT = 100;
    localparam int BIAS_UA_PER_COUNT = 2;
    localparam int PWR_NW_PER_COUNT = 100;
    // reset values
    localparam logic SOFT_TXOFF_RST = 1'b0;
    localparam logic RT_VALID_RST = 1'b0;
    localparam logic RX_FULL_BW = 1'b1;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage
`default_nettype wire

// *** tdmr_limit_cmp.sv ***
`timescale 1ns/10ps
`default_nettype none
module tdmr_limit_cmp #(
    parameter bit IS_SIGNED = 1'b0,
    parameter logic [15:0] HI_ALARM = 16'h0000,
    parameter logic [15:0] LO_ALARM = 16'h0000,
    parameter logic [15:0] HI_WARN = 16'h0000,
    parameter logic [15:0] LO_WARN = 16'h0000
) (
    input wire logic core_clk, // system clock
    input wire logic rst, // async reset, active high
    input wire logic valid, // reading is a real measurement
    input wire logic [15:0] reading, // current reading
    output logic hiAlarm, // reading above high alarm limit
    output logic loAlarm, // reading below low alarm limit
    output logic hiWarn, // reading above high warning limit
    output logic loWarn // reading below low warning limit
);
    function automatic logic above(input logic [15:0] a, input logic [15:0] b);
        if (IS_SIGNED) begin
            above = $signed(a) > $signed(b);
        end else begin
            above = a > b;
        end
    endfunction

    // flags are live: they follow the reading and drop while no reading is valid
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            hiAlarm <= 1'b0;
            loAlarm <= 1'b0;
            hiWarn <= 1'b0;
            loWarn <= 1'b0;
        end else begin
            hiAlarm <= valid && above(reading, HI_ALARM); // R22
            loAlarm <= valid && above(LO_ALARM, reading); // R22
            hiWarn <= valid && above(reading, HI_WARN); // R22
            loWarn <= valid && above(LO_WARN, reading); // R22
        end
    end

    property p_low_alarm_follows;
        @(posedge core_clk) disable iff (rst)
        (valid && above(LO_ALARM, reading)) |=> loAlarm;
    endproperty
    a_low_alarm_follows: assert property (p_low_alarm_follows) else $error("low alarm missed"); // R22
endmodule // tdmr_limit_cmp
`default_nettype wire

// *** tdmr_regs.sv ***
// Summary of operation
// R01 - temperature signed sixteen bits, 1/256 degree
// R02 - supply unsigned sixteen bits, 100 uV steps
// R03 - bias unsigned sixteen bits, 2 uA steps
// R04 - transmit power unsigned, 0.1 uW steps
// R05 - receive power unsigned, 0.1 uW steps
// R06 - byte 95 holds fixed factory checksum
// R07 - byte 127 write accepted, no effect
// R08 - bytes 128 to 247 user storage
// R09 - calibration range returns fixed defaults
// R10 - status shows transmitter-off pin level
// R11 - soft transmitter-off bit ORed with pin
// R12 - rate select reported, receiver stays full
// R13 - status mirrors transmit fault level
// R14 - status mirrors signal-absent level
// R15 - data-not-ready low once readings valid
// R16 - byte 112 alarm flags, temp first
// R17 - byte 113 receive power alarms
// R18 - byte 116 warning flags, same order
// R19 - byte 117 receive power warnings
// R20 - readings msb then lsb, bytes 96-105
// R21 - receive low warning at bit six
// R22 - high above limit, low below limit
//
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
module tdmr_regs #(
    parameter int ADDR_W = 10,
    parameter logic [319:0] THRESH_INIT = 320'h0,
    parameter logic [319:0] CAL_INIT = 320'h0
) (
    input wire logic core_clk, // system clock, 125 MHz
    input wire logic rst, // async reset, active high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // strobe
    input wire logic wb_we_i, // write enable
    input wire logic [ADDR_W-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte lanes
    input wire logic [31:0] wb_dat_i, // write data
    output logic [31:0] wb_dat_o, // read data
    output logic wb_ack_o, // acknowledge
    input wire logic measValid, // readings valid this cycle
    input wire logic [15:0] tempReading, // temperature
    input wire logic [15:0] vccReading, // supply voltage
    input wire logic [15:0] biasReading, // laser bias
    input wire logic [15:0] txPwrReading, // transmit power
    input wire logic [15:0] rxPwrReading, // receive power
    input wire logic txDisablePin, // transmitter-off pin
    input wire logic rateSelectPin, // rate select pin
    input wire logic txFaultPin, // transmit fault output level
    input wire logic signalAbsentOut, // receive signal-absent output level
    output logic txOff, // transmitter shut off
    output logic rxFullBw // receiver bandwidth, fixed full
);
    // refuse a bus narrower than the page
    if (ADDR_W < tdmr_pkg::PAGE_ADDR_BITS) begin : g_addr_check
        $error("ADDR_W too small for the page");
    end

    function automatic logic inRange(input logic [7:0] i, input logic [7:0] lo, input logic [7:0] hi);
        inRange = (i >= lo) && (i <= hi);
    endfunction

    function automatic logic [15:0] thWord(input int ch, input int off);
        int b;
        b = ch * tdmr_pkg::TH_BYTES_PER_CH + off;
        thWord = {THRESH_INIT[8*b +: 8], THRESH_INIT[8*(b+1) +: 8]};
    endfunction

    // factory checksum, fixed at elaboration and never recomputed
    function automatic logic [7:0] pageSum();
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < tdmr_pkg::THRESH_BYTES; i++) begin
            s = 8'(s + THRESH_INIT[8*i +: 8]);
        end
        for (int i = 0; i < tdmr_pkg::CAL_BYTES; i++) begin
            s = 8'(s + CAL_INIT[8*i +: 8]);
        end
        return s;
    endfunction

    localparam logic [7:0] CHECKSUM = pageSum();

    logic [7:0] idx;
    logic mapped;
    logic request;
    logic writeReq;
    logic [7:0] next_rdByte;
    logic softTxOff;
    logic rtValid;
    logic [15:0] rtWord [tdmr_pkg::NUM_CH];
    logic [15:0] measIn [tdmr_pkg::NUM_CH];
    logic [7:0] userMem [tdmr_pkg::USER_BYTES];
    logic [tdmr_pkg::NUM_CH-1:0] hiAlarm;
    logic [tdmr_pkg::NUM_CH-1:0] loAlarm;
    logic [tdmr_pkg::NUM_CH-1:0] hiWarn;
    logic [tdmr_pkg::NUM_CH-1:0] loWarn;
    logic [7:0] alarmPri;
    logic [7:0] alarmRx;
    logic [7:0] warnPri;
    logic [7:0] warnRx;
    logic [7:0] statusByte;
    logic [6:0] userIdx;
    logic [3:0] rtIdx;
    logic [5:0] calIdx;
    logic [5:0] thIdx;

    assign idx = wb_adr_i[tdmr_pkg::PAGE_ADDR_BITS-1:2];
    assign mapped = (wb_adr_i >> tdmr_pkg::PAGE_ADDR_BITS) == '0;
    assign request = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign writeReq = request && wb_we_i && wb_sel_i[0] && mapped;
    assign userIdx = 7'(idx - tdmr_pkg::IDX_USER_FIRST);
    assign rtIdx = 4'(idx - tdmr_pkg::IDX_RT_FIRST);
    assign calIdx = 6'(idx - tdmr_pkg::IDX_CAL_FIRST);
    assign thIdx = idx[5:0];

    assign measIn[tdmr_pkg::CH_TEMP] = tempReading; // R01
    assign measIn[tdmr_pkg::CH_VCC] = vccReading; // R02
    assign measIn[tdmr_pkg::CH_BIAS] = biasReading; // R03
    assign measIn[tdmr_pkg::CH_TXPWR] = txPwrReading; // R04
    assign measIn[tdmr_pkg::CH_RXPWR] = rxPwrReading; // R05

    // readings are captured while valid and held otherwise
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rtValid <= tdmr_pkg::RT_VALID_RST;
            for (int c = 0; c < tdmr_pkg::NUM_CH; c++) begin
                rtWord[c] <= 16'h0000;
            end
        end else begin
            rtValid <= measValid; // R15
            if (measValid) begin
                for (int c = 0; c < tdmr_pkg::NUM_CH; c++) begin
                    rtWord[c] <= measIn[c];
                end
            end
        end
    end

    genvar ch;
    generate
        for (ch = 0; ch < tdmr_pkg::NUM_CH; ch++) begin : g_cmp
            tdmr_limit_cmp #(
                .IS_SIGNED(ch == tdmr_pkg::CH_TEMP),
                .HI_ALARM(thWord(ch, tdmr_pkg::TH_HI_ALARM)),
                .LO_ALARM(thWord(ch, tdmr_pkg::TH_LO_ALARM)),
                .HI_WARN(thWord(ch, tdmr_pkg::TH_HI_WARN)),
                .LO_WARN(thWord(ch, tdmr_pkg::TH_LO_WARN))
            ) u_cmp (
                .core_clk(core_clk),
                .rst(rst),
                .valid(rtValid),
                .reading(rtWord[ch]),
                .hiAlarm(hiAlarm[ch]),
                .loAlarm(loAlarm[ch]),
                .hiWarn(hiWarn[ch]),
                .loWarn(loWarn[ch])
            );
        end
        for (ch = 0; ch < tdmr_pkg::CH_RXPWR; ch++) begin : g_flags
            assign alarmPri[7-2*ch] = hiAlarm[ch]; // R16
            assign alarmPri[6-2*ch] = loAlarm[ch]; // R16
            assign warnPri[7-2*ch] = hiWarn[ch]; // R18
            assign warnPri[6-2*ch] = loWarn[ch]; // R18
        end
    endgenerate

    assign alarmRx = {hiAlarm[tdmr_pkg::CH_RXPWR], loAlarm[tdmr_pkg::CH_RXPWR], 6'h00}; // R17
    assign warnRx = {hiWarn[tdmr_pkg::CH_RXPWR], loWarn[tdmr_pkg::CH_RXPWR], 6'h00}; // R19 R21

    always_comb begin
        statusByte = tdmr_pkg::BYTE_ZERO;
        statusByte[tdmr_pkg::ST_TXDIS_PIN] = txDisablePin; // R10
        statusByte[tdmr_pkg::ST_SOFT_TXOFF] = softTxOff; // R11
        statusByte[tdmr_pkg::ST_RATE_SEL] = rateSelectPin; // R12
        statusByte[tdmr_pkg::ST_TX_FAULT] = txFaultPin; // R13
        statusByte[tdmr_pkg::ST_SIG_ABSENT] = signalAbsentOut; // R14
        statusByte[tdmr_pkg::ST_DATA_NOT_READY] = !rtValid; // R15
    end

    // read decode; reserved, vendor and unmapped bytes read zero
    always_comb begin
        next_rdByte = tdmr_pkg::BYTE_ZERO;
        if (!mapped) begin
            next_rdByte = tdmr_pkg::BYTE_ZERO;
        end else if (inRange(idx, tdmr_pkg::IDX_THRESH_FIRST, tdmr_pkg::IDX_THRESH_LAST)) begin
            next_rdByte = THRESH_INIT[8*thIdx +: 8];
        end else if (inRange(idx, tdmr_pkg::IDX_CAL_FIRST, tdmr_pkg::IDX_CAL_LAST)) begin
            next_rdByte = CAL_INIT[8*calIdx +: 8]; // R09
        end else if (idx == tdmr_pkg::IDX_CHECKSUM) begin
            next_rdByte = CHECKSUM; // R06
        end else if (inRange(idx, tdmr_pkg::IDX_RT_FIRST, tdmr_pkg::IDX_RT_LAST)) begin
            next_rdByte = rtIdx[0] ? rtWord[rtIdx[3:1]][7:0] : rtWord[rtIdx[3:1]][15:8]; // R20
        end else if (inRange(idx, tdmr_pkg::IDX_USER_FIRST, tdmr_pkg::IDX_USER_LAST)) begin
            next_rdByte = userMem[userIdx]; // R08
        end else begin
            case (idx)
                tdmr_pkg::IDX_STATUS: next_rdByte = statusByte;
                tdmr_pkg::IDX_ALARM_PRI: next_rdByte = alarmPri;
                tdmr_pkg::IDX_ALARM_RX: next_rdByte = alarmRx;
                tdmr_pkg::IDX_WARN_PRI: next_rdByte = warnPri;
                tdmr_pkg::IDX_WARN_RX: next_rdByte = warnRx;
                tdmr_pkg::IDX_LEGACY: next_rdByte = tdmr_pkg::BYTE_ZERO; // R07
                default: next_rdByte = tdmr_pkg::BYTE_ZERO;
            endcase
        end
    end

    // every access is acknowledged one cycle after the strobe, mapped or not
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= request;
            if (request) begin
                wb_dat_o <= {24'h00_0000, next_rdByte};
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            softTxOff <= tdmr_pkg::SOFT_TXOFF_RST;
        end else if (writeReq && idx == tdmr_pkg::IDX_STATUS) begin
            softTxOff <= wb_dat_i[tdmr_pkg::ST_SOFT_TXOFF]; // R11
        end
    end

    // the legacy byte and all read-only bytes simply drop the write
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < tdmr_pkg::USER_BYTES; i++) begin
                userMem[i] <= tdmr_pkg::BYTE_ZERO;
            end
        end else if (writeReq && inRange(idx, tdmr_pkg::IDX_USER_FIRST, tdmr_pkg::IDX_USER_LAST)) begin
            userMem[userIdx] <= wb_dat_i[7:0]; // R08
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            txOff <= 1'b0;
            rxFullBw <= tdmr_pkg::RX_FULL_BW;
        end else begin
            txOff <= txDisablePin || softTxOff; // R11
            rxFullBw <= tdmr_pkg::RX_FULL_BW; // R12
        end
    end

    logic readReq;
    assign readReq = request && !wb_we_i && mapped;

    property p_ack_once;
        @(posedge core_clk) disable iff (rst)
        request |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack not a single cycle after request");

    property p_soft_off;
        @(posedge core_clk) disable iff (rst)
        (writeReq && idx == tdmr_pkg::IDX_STATUS && wb_dat_i[tdmr_pkg::ST_SOFT_TXOFF]) |=> ##1 txOff;
    endproperty
    a_soft_off: assert property (p_soft_off) else $error("soft off did not shut transmitter"); // R11

    property p_pin_off;
        @(posedge core_clk) disable iff (rst)
        txDisablePin |=> txOff;
    endproperty
    a_pin_off: assert property (p_pin_off) else $error("pin did not shut transmitter"); // R11

    property p_status_pins;
        @(posedge core_clk) disable iff (rst)
        (readReq && idx == tdmr_pkg::IDX_STATUS) |=>
            (wb_dat_o[tdmr_pkg::ST_TXDIS_PIN] == $past(txDisablePin))
            && (wb_dat_o[tdmr_pkg::ST_TX_FAULT] == $past(txFaultPin))
            && (wb_dat_o[tdmr_pkg::ST_SIG_ABSENT] == $past(signalAbsentOut))
            && (wb_dat_o[tdmr_pkg::ST_RATE_SEL] == $past(rateSelectPin));
    endproperty
    a_status_pins: assert property (p_status_pins) else $error("status byte does not mirror pins"); // R10

    property p_not_ready;
        @(posedge core_clk) disable iff (rst)
        (readReq && idx == tdmr_pkg::IDX_STATUS) |=>
            wb_dat_o[tdmr_pkg::ST_DATA_NOT_READY] == !$past(measValid, 2);
    endproperty
    a_not_ready: assert property (p_not_ready) else $error("data-not-ready bit wrong"); // R15

    property p_checksum;
        @(posedge core_clk) disable iff (rst)
        (readReq && idx == tdmr_pkg::IDX_CHECKSUM) |=> wb_dat_o == {24'h00_0000, CHECKSUM};
    endproperty
    a_checksum: assert property (p_checksum) else $error("checksum byte changed"); // R06

    property p_legacy;
        @(posedge core_clk) disable iff (rst)
        (readReq && idx == tdmr_pkg::IDX_LEGACY) |=> wb_dat_o == 32'h0000_0000;
    endproperty
    a_legacy: assert property (p_legacy) else $error("legacy byte not zero"); // R07

    property p_user_keep;
        @(posedge core_clk) disable iff (rst)
        (writeReq && inRange(idx, tdmr_pkg::IDX_USER_FIRST, tdmr_pkg::IDX_USER_LAST))
            |=> userMem[$past(userIdx)] == $past(wb_dat_i[7:0]);
    endproperty
    a_user_keep: assert property (p_user_keep) else $error("user byte not stored"); // R08

    property p_temp_msb;
        @(posedge core_clk) disable iff (rst)
        (readReq && idx == tdmr_pkg::IDX_RT_FIRST) |=> wb_dat_o[7:0] == $past(rtWord[tdmr_pkg::CH_TEMP][15:8]);
    endproperty
    a_temp_msb: assert property (p_temp_msb) else $error("temperature msb misplaced"); // R20

    property p_temp_high;
        @(posedge core_clk) disable iff (rst)
        (rtValid && $signed(rtWord[tdmr_pkg::CH_TEMP]) > $signed(thWord(tdmr_pkg::CH_TEMP, tdmr_pkg::TH_HI_ALARM)))
            |=> alarmPri[7];
    endproperty
    a_temp_high: assert property (p_temp_high) else $error("temperature high alarm missed"); // R16

    property p_rx_low_warn;
        @(posedge core_clk) disable iff (rst)
        (rtValid && rtWord[tdmr_pkg::CH_RXPWR] < thWord(tdmr_pkg::CH_RXPWR, tdmr_pkg::TH_LO_WARN))
            |=> warnRx[tdmr_pkg::RX_LO_BIT];
    endproperty
    a_rx_low_warn: assert property (p_rx_low_warn) else $error("receive low warning missed"); // R21

    property p_full_bw;
        @(posedge core_clk) disable iff (rst)
        $changed(rateSelectPin) |=> ##1 rxFullBw;
    endproperty
    a_full_bw: assert property (p_full_bw) else $error("receiver left full bandwidth"); // R12

    property p_cov_user_write;
        @(posedge core_clk) disable iff (rst)
        writeReq && inRange(idx, tdmr_pkg::IDX_USER_FIRST, tdmr_pkg::IDX_USER_LAST);
    endproperty
    c_user_write: cover property (p_cov_user_write);

    property p_cov_status_read;
        @(posedge core_clk) disable iff (rst)
        readReq && idx == tdmr_pkg::IDX_STATUS && rtValid;
    endproperty
    c_status_read: cover property (p_cov_status_read);

    property p_cov_alarm;
        @(posedge core_clk) disable iff (rst)
        $rose(alarmPri[7]);
    endproperty
    c_alarm: cover property (p_cov_alarm);

    property p_cov_soft_off;
        @(posedge core_clk) disable iff (rst)
        $rose(softTxOff) && !txDisablePin ##1 txOff;
    endproperty
    c_soft_off: cover property (p_cov_soft_off);
endmodule // tdmr_regs
`default_nettype wire

// *** tdmr_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module tdmr_host #(
    parameter int ADDR_W = 11
) (
    input wire logic core_clk, // system clock
    output logic wbCyc, // cycle
    output logic wbStb, // strobe
    output logic wbWe, // write enable
    output logic [ADDR_W-1:0] wbAdr, // byte address
    output logic [3:0] wbSel, // byte lanes
    output logic [31:0] wbDatW, // write data
    input wire logic [31:0] wbDatR, // read data
    input wire logic wbAck // acknowledge
);
    initial begin
        wbCyc = 1'b0;
        wbStb = 1'b0;
        wbWe = 1'b0;
        wbAdr = '0;
        wbSel = 4'h1;
        wbDatW = 32'h0000_0000;
    end

    // one classic cycle: request held until ack is sampled, then released
    task automatic xfer(input logic we, input logic [ADDR_W-1:0] adr, input logic [3:0] sel,
                        input logic [7:0] din, output logic [31:0] dout);
        @(posedge core_clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= we;
        wbAdr <= adr;
        wbSel <= sel;
        wbDatW <= {24'h00_0000, din};
        do @(posedge core_clk); while (wbAck !== 1'b1);
        dout = wbDatR;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
        // released data lines toggle so a stale value never looks valid
        wbDatW <= ~wbDatW;
    endtask
endmodule // tdmr_host
`default_nettype wire

// *** tb_top.sv ***
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    localparam logic [319:0] TH = {5{64'h0020_0030_0010_0040}};
    localparam logic [319:0] CAL = {40{8'h5a}};
    localparam logic [15:0] RS [3][5] = '{'{16'h4001, 16'h0fff, 16'h4001, 16'h0fff, 16'h4001},
        '{16'he700, 16'h4001, 16'h0fff, 16'h4001, 16'h0fff},
        '{16'h4000, 16'h4000, 16'h4000, 16'h4000, 16'h4000}};
    localparam logic [31:0] FL [3] = '{32'h9980_9980, 32'h6640_6640, 32'h0000_aa80};
    logic core_clk;
    logic rst;
    logic wbCyc;
    logic wbStb;
    logic wbWe;
    logic [10:0] wbAdr;
    logic [3:0] wbSel;
    logic [31:0] wbDatW;
    logic [31:0] wbDatR;
    logic wbAck;
    logic measValid;
    logic [15:0] rdg [5];
    logic txDisablePin, rateSelectPin, txFaultPin, signalAbsentOut;
    logic txOff;
    logic rxFullBw;
    int nMismatch;
    int testsRun;
    int cycles;

    tdmr_regs #(.ADDR_W(11), .THRESH_INIT(TH), .CAL_INIT(CAL)) tdmr_regs_i (
        .core_clk(core_clk), .rst(rst), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatW), .wb_dat_o(wbDatR), .wb_ack_o(wbAck),
        .measValid(measValid), .tempReading(rdg[0]), .vccReading(rdg[1]), .biasReading(rdg[2]),
        .txPwrReading(rdg[3]), .rxPwrReading(rdg[4]), .txDisablePin(txDisablePin),
        .rateSelectPin(rateSelectPin), .txFaultPin(txFaultPin), .signalAbsentOut(signalAbsentOut),
        .txOff(txOff), .rxFullBw(rxFullBw));

    tdmr_host #(.ADDR_W(11)) tdmr_host_i (
        .core_clk(core_clk), .wbCyc(wbCyc), .wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr),
        .wbSel(wbSel), .wbDatW(wbDatW), .wbDatR(wbDatR), .wbAck(wbAck));

    task automatic end_of_test();
        if (nMismatch == 0 && testsRun > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        testsRun++;
        if (seen !== exp) begin
            nMismatch++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // index bit 8 lands on an address bit above the page
    task automatic wr(input logic [8:0] idx, input logic [7:0] d);
        logic [31:0] x;
        tdmr_host_i.xfer(1'b1, {idx, 2'b00}, 4'h1, d, x);
    endtask

    // write with lane 0 disabled must be dropped
    task automatic wrn(input logic [8:0] idx, input logic [7:0] d);
        logic [31:0] x;
        tdmr_host_i.xfer(1'b1, {idx, 2'b00}, 4'he, d, x);
    endtask

    task automatic rdb(input logic [8:0] idx, input logic [7:0] e);
        logic [31:0] x;
        tdmr_host_i.xfer(1'b0, {idx, 2'b00}, 4'h1, 8'h00, x);
        chk(x, {24'h00_0000, e});
    endtask

    function automatic logic [7:0] csum();
        logic [7:0] s;
        s = 8'h00;
        for (int k = 0; k < 40; k++) s += TH[8*k +: 8] + CAL[8*k +: 8];
        return s;
    endfunction

    task automatic t_reset();
        rdb(9'h06e, 8'h01);
        rdb(9'h070, 8'h00);
        chk({31'h0, txOff}, 32'h0);
        chk({31'h0, rxFullBw}, 32'h1);
    endtask

    task automatic t_readings();
        for (int s = 0; s < 3; s++) begin
            @(posedge core_clk);
            measValid <= 1'b1;
            for (int c = 0; c < 5; c++) rdg[c] <= RS[s][c];
            repeat (2) @(posedge core_clk);
            for (int c = 0; c < 5; c++) begin
                rdb(9'h060 + 9'(2 * c), RS[s][c][15:8]);
                rdb(9'h061 + 9'(2 * c), RS[s][c][7:0]);
            end
            rdb(9'h070, FL[s][31:24]);
            rdb(9'h071, FL[s][23:16]);
            rdb(9'h074, FL[s][15:8]);
            rdb(9'h075, FL[s][7:0]);
            rdb(9'h06e, 8'h00);
        end
        @(posedge core_clk);
        measValid <= 1'b0;
        rdb(9'h06e, 8'h01);
        rdb(9'h074, 8'h00);
        rdb(9'h060, RS[2][0][15:8]);
    endtask

    task automatic t_status();
        int pos [4] = '{7, 4, 2, 1};
        measValid <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge core_clk);
            {txDisablePin, rateSelectPin, txFaultPin, signalAbsentOut} <= 4'h8 >> i;
            rdb(9'h06e, 8'h01 << pos[i]);
            chk({31'h0, txOff}, {31'h0, i == 0});
            chk({31'h0, rxFullBw}, 32'h1);
        end
        @(posedge core_clk);
        {txDisablePin, rateSelectPin, txFaultPin, signalAbsentOut} <= 4'h0;
        wr(9'h06e, 8'hff);
        rdb(9'h06e, 8'h40);
        chk({31'h0, txOff}, 32'h1);
        wr(9'h06e, 8'h00);
        @(posedge core_clk);
        chk({31'h0, txOff}, 32'h0);
    endtask

    task automatic t_memory();
        wr(9'h080, 8'ha5);
        wr(9'h0f7, 8'h3c);
        wr(9'h0f8, 8'h77);
        wr(9'h07f, 8'hff);
        wr(9'h05f, 8'h00);
        wr(9'h180, 8'hff);
        wrn(9'h081, 8'h55);
        rdb(9'h081, 8'h00);
        rdb(9'h080, 8'ha5);
        rdb(9'h0f7, 8'h3c);
        rdb(9'h0f8, 8'h00);
        rdb(9'h07f, 8'h00);
        rdb(9'h05f, csum());
        rdb(9'h037, 8'h5a);
        rdb(9'h05e, 8'h5a);
        rdb(9'h180, 8'h00);
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            nMismatch++;
            end_of_test();
        end
    end

    initial begin
        rst = 1'b1;
        measValid = 1'b0;
        for (int c = 0; c < 5; c++) rdg[c] = 16'h0000;
        {txDisablePin, rateSelectPin, txFaultPin, signalAbsentOut} = 4'h0;
        nMismatch = 0;
        testsRun = 0;
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        t_reset();
        t_readings();
        t_status();
        t_memory();
        end_of_test();
    end
endmodule // tb_top
`default_nettype wire
